// ---- core/dtc_consts.vh ----
/*
 * constants for the dual timer / event counter: register offsets, field
 * positions, reset values and timing counts. assumes a byte-wide sfr port.
 */
`ifndef DTC_CONSTS_VH
`define DTC_CONSTS_VH

// register offsets
`define DTC_ADDR_MODE        8'h89
`define DTC_ADDR_CTRL        8'h88
`define DTC_ADDR_TL0         8'h8A
`define DTC_ADDR_TL1         8'h8B
`define DTC_ADDR_TH0         8'h8C
`define DTC_ADDR_TH1         8'h8D
`define DTC_ADDR_TOGGLE      8'h8E

// mode register fields, timer 1 in upper nibble
`define DTC_GATE1_BIT        7
`define DTC_SRC1_BIT         6
`define DTC_MODE1_HI         5
`define DTC_MODE1_LO         4
`define DTC_GATE0_BIT        3
`define DTC_SRC0_BIT         2
`define DTC_MODE0_HI         1
`define DTC_MODE0_LO         0

// control register fields
`define DTC_OVF1_BIT         7
`define DTC_RUN1_BIT         6
`define DTC_OVF0_BIT         5
`define DTC_RUN0_BIT         4

// toggle enable register fields
`define DTC_TOG0_BIT         0
`define DTC_TOG1_BIT         1

// reset values
`define DTC_MODE_RESET       8'h00
`define DTC_CTRL_RESET       8'h00
`define DTC_COUNT_RESET      8'h00
`define DTC_TOGGLE_RESET     8'h00

// mode encodings
`define DTC_MODE_13BIT       2'b00
`define DTC_MODE_16BIT       2'b01
`define DTC_MODE_RELOAD      2'b10
`define DTC_MODE_SPLIT       2'b11

// machine cycle length in cpu clocks
`define DTC_CLKS_PER_MCYCLE  6

`endif

// ---- core/dtc_timer.v ----
/*
 * two up-counting timer / event counters with mode register, control
 * register, count bytes and overflow toggle outputs on the event pins.
 * assumes event and gate pins are already synchronous to sys_clk.
 */
`timescale 1ns/1ps
`include "dtc_consts.vh"

// Function
// (RULE1) In timer function a counter advances once per machine cycle of six clocks.
// (RULE2) In counter function a counter advances on a falling edge of its own event pin.
// (RULE3) The event pin is sampled once per machine cycle and counts on a high then low sample.
// (RULE4) The new count is visible in the machine cycle after the one that saw the edge.
// (RULE5) Recognising a falling edge takes two machine cycles, twelve clocks.
// (RULE6) The driving source holds each event pin level at least one machine cycle.
// (RULE7) Source select bit 6 (timer 1) and bit 2 (timer 0) pick machine cycles at 0, pin at 1.
// (RULE8) Mode fields sit at bits 5:4 for timer 1 and bits 1:0 for timer 0.
// (RULE9) Modes 0 to 2 match for both timers, mode 3 differs between them.
// (RULE10) With gate set a timer counts only while its gate pin is high and run is set.
// (RULE11) Each timer may toggle its event pin on every overflow, the pin then being an output.
// (RULE12) Mode 0 is a 13-bit counter of high byte and low five bits of the low byte.
// (RULE13) Mode 1 cascades all sixteen bits with no prescaler.
// (RULE14) Mode 2 counts the low byte and reloads it from the high byte on overflow.
// (RULE15) Mode 3 splits timer 0 in two, the high byte using timer 1 run and flag; timer 1 stops.
// (RULE16) A timer whose run and gate conditions fail holds its count.
module dtc_timer (
    // clock and reset
    input  wire       sys_clk,
    input  wire       reset_n,
    // register port
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    // event pins, output enable active low
    input  wire       event_pin_zero_in,
    output reg        event_pin_zero_out,
    output reg        event_pin_zero_oe_n,
    input  wire       event_pin_one_in,
    output reg        event_pin_one_out,
    output reg        event_pin_one_oe_n,
    // gate pins
    input  wire       gate_pin_zero,
    input  wire       gate_pin_one,
    // overflow flags as levels
    output reg        overflow_flag_zero,
    output reg        overflow_flag_one
);

    localparam integer MCYC_LEN  = `DTC_CLKS_PER_MCYCLE;
    localparam [2:0]   MCYC_LAST = MCYC_LEN[2:0] - 3'h1;

    reg  [7:0] timer_mode_control_reg;
    reg  [7:0] ctrl_reg;
    reg  [7:0] toggle_en_reg;
    reg  [7:0] tl0_reg, th0_reg, tl1_reg, th1_reg;
    reg  [2:0] mcyc_cnt_reg;
    reg        ev0_smp_reg, ev1_smp_reg;
    reg        ev0_edge_reg, ev1_edge_reg;

    wire       mcyc_tick = (mcyc_cnt_reg == MCYC_LAST); // [RULE1]

    wire       run0  = ctrl_reg[`DTC_RUN0_BIT];
    wire       run1  = ctrl_reg[`DTC_RUN1_BIT];
    wire [1:0] mode0 = timer_mode_control_reg[`DTC_MODE0_HI:`DTC_MODE0_LO]; // [RULE8]
    wire [1:0] mode1 = timer_mode_control_reg[`DTC_MODE1_HI:`DTC_MODE1_LO]; // [RULE8]
    wire       src0  = timer_mode_control_reg[`DTC_SRC0_BIT];
    wire       src1  = timer_mode_control_reg[`DTC_SRC1_BIT];
    wire       gate0 = timer_mode_control_reg[`DTC_GATE0_BIT];
    wire       gate1 = timer_mode_control_reg[`DTC_GATE1_BIT];

    // event pin reads back our own drive while toggling, so count from input
    wire       ev0_pin = event_pin_zero_in;
    wire       ev1_pin = event_pin_one_in;

    // register port hit: strobe high and address match
    function dtc_hit;
        input       strobe;
        input [7:0] addr;
        input [7:0] target;
        begin
            dtc_hit = strobe & (addr == target);
        end
    endfunction

    // count enable: run set and either no gate or gate pin high
    function dtc_enable;
        input run;
        input gate;
        input gate_pin;
        begin
            dtc_enable = run & (~gate | gate_pin);
        end
    endfunction

    // falling edge: last sample high, present level low
    function dtc_fall;
        input last_smp;
        input pin_now;
        begin
            dtc_fall = last_smp & ~pin_now;
        end
    endfunction

    // toggle output: forced high while disabled so the pin idles high
    function dtc_toggle;
        input enable;
        input ovf;
        input cur;
        begin
            if (!enable) begin
                dtc_toggle = 1'b1;
            end else if (ovf) begin
                dtc_toggle = ~cur;
            end else begin
                dtc_toggle = cur;
            end
        end
    endfunction

    // counting enable: run and (no gate or gate pin high), timer 1 also off in mode 3
    wire       en0 = dtc_enable(run0, gate0, gate_pin_zero); // [RULE10] [RULE16]
    wire       en1 = dtc_enable(run1, gate1, gate_pin_one)
                     & (mode1 != `DTC_MODE_SPLIT); // [RULE10] [RULE15]

    // count pulse: machine cycle or a detected falling edge, one per mcycle
    wire       pulse0 = en0 & mcyc_tick & (src0 ? ev0_edge_reg : 1'b1); // [RULE7] [RULE4]
    wire       pulse1 = en1 & mcyc_tick & (src1 ? ev1_edge_reg : 1'b1); // [RULE7]
    // split high byte: machine cycles only, under timer 1 run bit
    wire       pulse_h0 = (mode0 == `DTC_MODE_SPLIT) & run1 & mcyc_tick; // [RULE15]

    // one step of a timer in modes 0..2 (mode 3 timer 0 low byte acts 8-bit)
    function [16:0] dtc_step;
        input [1:0] mode;
        input [7:0] tl;
        input [7:0] th;
        reg   [16:0] n;
        begin
            n = {1'b0, th, tl};
            case (mode)
                `DTC_MODE_13BIT: begin // [RULE12]
                    n[4:0] = tl[4:0] + 5'h01;
                    if (tl[4:0] == 5'h1F) begin
                        n[15:8] = th + 8'h01;
                        n[16]   = (th == 8'hFF);
                    end
                end
                `DTC_MODE_16BIT: begin // [RULE13]
                    n = {1'b0, th, tl} + 17'h00001;
                end
                `DTC_MODE_RELOAD: begin // [RULE14]
                    n[16]  = (tl == 8'hFF);
                    n[7:0] = (tl == 8'hFF) ? th : tl + 8'h01;
                end
                default: begin // [RULE15]
                    n[16]  = (tl == 8'hFF);
                    n[7:0] = tl + 8'h01;
                end
            endcase
            dtc_step = n;
        end
    endfunction

    wire [16:0] step0 = dtc_step(mode0, tl0_reg, th0_reg); // [RULE9]
    wire [16:0] step1 = dtc_step(mode1, tl1_reg, th1_reg); // [RULE9]
    wire        ovf0  = pulse0 & step0[16];
    wire        ovf1  = pulse1 & step1[16];
    wire        ovf_h0 = pulse_h0 & (th0_reg == 8'hFF);
    // in split mode timer 1 overflow flag belongs to the timer 0 high byte
    wire        set_f1 = (mode0 == `DTC_MODE_SPLIT) ? ovf_h0 : ovf1; // [RULE15]

    wire wr_mode = dtc_hit(reg_wr, reg_addr, `DTC_ADDR_MODE);
    wire wr_ctrl = dtc_hit(reg_wr, reg_addr, `DTC_ADDR_CTRL);
    wire wr_tl0  = dtc_hit(reg_wr, reg_addr, `DTC_ADDR_TL0);
    wire wr_th0  = dtc_hit(reg_wr, reg_addr, `DTC_ADDR_TH0);
    wire wr_tl1  = dtc_hit(reg_wr, reg_addr, `DTC_ADDR_TL1);
    wire wr_th1  = dtc_hit(reg_wr, reg_addr, `DTC_ADDR_TH1);
    wire wr_tog  = dtc_hit(reg_wr, reg_addr, `DTC_ADDR_TOGGLE);

    // machine cycle divider
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            mcyc_cnt_reg <= 3'h0;
        end else if (mcyc_tick) begin
            mcyc_cnt_reg <= 3'h0;
        end else begin
            mcyc_cnt_reg <= mcyc_cnt_reg + 3'h1;
        end
    end

    // pin sampling once per machine cycle; edge flag lasts one mcycle
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ev0_smp_reg  <= 1'b0;
            ev1_smp_reg  <= 1'b0;
            ev0_edge_reg <= 1'b0;
            ev1_edge_reg <= 1'b0;
        end else if (mcyc_tick) begin
            ev0_smp_reg  <= ev0_pin; // [RULE3] [RULE6]
            ev1_smp_reg  <= ev1_pin; // [RULE3]
            ev0_edge_reg <= dtc_fall(ev0_smp_reg, ev0_pin); // [RULE2] [RULE3] [RULE5]
            ev1_edge_reg <= dtc_fall(ev1_smp_reg, ev1_pin); // [RULE2] [RULE3] [RULE5]
        end
    end

    // registers and counters; software write wins over counting
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            timer_mode_control_reg <= `DTC_MODE_RESET;
            ctrl_reg               <= `DTC_CTRL_RESET;
            toggle_en_reg          <= `DTC_TOGGLE_RESET;
            tl0_reg                <= `DTC_COUNT_RESET;
            th0_reg                <= `DTC_COUNT_RESET;
            tl1_reg                <= `DTC_COUNT_RESET;
            th1_reg                <= `DTC_COUNT_RESET;
        end else begin
            if (wr_mode) begin
                timer_mode_control_reg <= reg_wdata;
            end
            if (wr_tog) begin
                toggle_en_reg <= reg_wdata & 8'h03;
            end
            if (wr_ctrl) begin
                ctrl_reg[`DTC_RUN1_BIT] <= reg_wdata[`DTC_RUN1_BIT];
                ctrl_reg[`DTC_RUN0_BIT] <= reg_wdata[`DTC_RUN0_BIT];
            end
            // hardware set wins over software clear
            ctrl_reg[`DTC_OVF0_BIT] <= ovf0 |
                (wr_ctrl ? reg_wdata[`DTC_OVF0_BIT] : ctrl_reg[`DTC_OVF0_BIT]);
            ctrl_reg[`DTC_OVF1_BIT] <= set_f1 |
                (wr_ctrl ? reg_wdata[`DTC_OVF1_BIT] : ctrl_reg[`DTC_OVF1_BIT]);
            if (wr_tl0) begin
                tl0_reg <= reg_wdata;
            end else if (pulse0) begin
                tl0_reg <= step0[7:0]; // [RULE1] [RULE2]
            end
            if (wr_th0) begin
                th0_reg <= reg_wdata;
            end else if (mode0 == `DTC_MODE_SPLIT) begin
                if (pulse_h0) begin
                    th0_reg <= th0_reg + 8'h01; // [RULE15]
                end
            end else if (pulse0) begin
                th0_reg <= step0[15:8];
            end
            if (wr_tl1) begin
                tl1_reg <= reg_wdata;
            end else if (pulse1) begin
                tl1_reg <= step1[7:0];
            end
            if (wr_th1) begin
                th1_reg <= reg_wdata;
            end else if (pulse1) begin
                th1_reg <= step1[15:8];
            end
        end
    end

    // toggle outputs: high before first overflow, flip on each overflow
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            event_pin_zero_out  <= 1'b1;
            event_pin_one_out   <= 1'b1;
            event_pin_zero_oe_n <= 1'b1;
            event_pin_one_oe_n  <= 1'b1;
        end else begin
            event_pin_zero_oe_n <= ~toggle_en_reg[`DTC_TOG0_BIT]; // [RULE11]
            event_pin_one_oe_n  <= ~toggle_en_reg[`DTC_TOG1_BIT]; // [RULE11]
            event_pin_zero_out  <= dtc_toggle(toggle_en_reg[`DTC_TOG0_BIT], ovf0,
                                              event_pin_zero_out); // [RULE11]
            event_pin_one_out   <= dtc_toggle(toggle_en_reg[`DTC_TOG1_BIT], ovf1,
                                              event_pin_one_out); // [RULE11]
        end
    end

    // read data one cycle after the strobe, flag outputs one cycle behind the control register
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata          <= 8'h00;
            overflow_flag_zero <= 1'b0;
            overflow_flag_one  <= 1'b0;
        end else begin
            overflow_flag_zero <= ctrl_reg[`DTC_OVF0_BIT];
            overflow_flag_one  <= ctrl_reg[`DTC_OVF1_BIT];
            if (reg_rd) begin
                case (reg_addr)
                    `DTC_ADDR_MODE:   reg_rdata <= timer_mode_control_reg;
                    `DTC_ADDR_CTRL:   reg_rdata <= ctrl_reg;
                    `DTC_ADDR_TL0:    reg_rdata <= tl0_reg;
                    `DTC_ADDR_TH0:    reg_rdata <= th0_reg;
                    `DTC_ADDR_TL1:    reg_rdata <= tl1_reg;
                    `DTC_ADDR_TH1:    reg_rdata <= th1_reg;
                    `DTC_ADDR_TOGGLE: reg_rdata <= toggle_en_reg;
                    default:          reg_rdata <= 8'h00;
                endcase
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end

endmodule // dtc_timer

// ---- testbench/dtc_pin_model.sv ----
/*
 * event pin source for timer 0 counter tests.
 * assumes the bench resolves the pin against the timer's toggle drive.
 */
`timescale 1ns/1ps
module dtc_pin_model (
    // clock and request
    input  wire       sys_clk,
    input  wire       start,
    input  wire [7:0] edges,
    // driven pin
    output reg        pin
);
    integer i;
    initial pin = 1'b1;
    // levels held two machine cycles so every level is sampled
    always @(posedge start) begin
        for (i = 0; i < edges; i = i + 1) begin
            repeat (12) @(posedge sys_clk);
            pin <= 1'b0;
            repeat (12) @(posedge sys_clk);
            pin <= 1'b1;
        end
    end
endmodule // dtc_pin_model

// ---- testbench/dtc_timer_monitor.sv ----
/*
 * port assertions for the dual timer.
 * assumes the dtc_timer port names and the offsets of dtc_consts.vh.
 */
`timescale 1ns/1ps
`include "dtc_consts.vh"
module dtc_timer_monitor (
    // clock and reset
    input wire       sys_clk,
    input wire       reset_n,
    // register port
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    // pin and flag
    input wire       event_pin_zero_out,
    input wire       event_pin_zero_oe_n,
    input wire       overflow_flag_zero
);
    reg [2:0] ctrl_wr_d;
    reg [2:0] tog_wr_d;
    // short history, effects land one or two cycles after the write
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_wr_d <= 3'h0;
            tog_wr_d <= 3'h0;
        end else begin
            ctrl_wr_d <= {ctrl_wr_d[1:0], reg_wr && reg_addr == `DTC_ADDR_CTRL};
            tog_wr_d <= {tog_wr_d[1:0], reg_wr && reg_addr == `DTC_ADDR_TOGGLE};
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    sequence s_mode_wr;
        reg_wr && reg_addr == `DTC_ADDR_MODE;
    endsequence
    sequence s_mode_rd;
        reg_rd && !reg_wr && reg_addr == `DTC_ADDR_MODE;
    endsequence
    a_mode_read_back: assert property (
        s_mode_wr ##2 s_mode_rd |=> reg_rdata == $past(reg_wdata, 3)) else $error("mode readback");
    a_rdata_idle_zero: assert property (
        !reg_rd |=> reg_rdata == 8'h00) else $error("rdata not zero");
    a_unmapped_reads_zero: assert property (
        reg_rd && (reg_addr < `DTC_ADDR_CTRL || reg_addr > `DTC_ADDR_TOGGLE)
        |=> reg_rdata == 8'h00) else $error("unmapped read");
    a_ctrl_low_zero: assert property (
        reg_rd && reg_addr == `DTC_ADDR_CTRL |=> reg_rdata[3:0] == 4'h0) else $error("ctrl low");
    a_pin_out_idle: assert property (
        event_pin_zero_oe_n [*2] |-> event_pin_zero_out) else $error("idle toggle out");
    a_toggle_needs_ovf: assert property (
        !event_pin_zero_oe_n && !$past(event_pin_zero_oe_n) && $changed(event_pin_zero_out)
        |-> ##[0:2] overflow_flag_zero) else $error("toggle without overflow");
    a_flag_sw_clear: assert property (
        $fell(overflow_flag_zero) |-> |ctrl_wr_d) else $error("flag lost");
    a_oe_needs_write: assert property (
        $changed(event_pin_zero_oe_n) |-> |tog_wr_d) else $error("oe change");
endmodule // dtc_timer_monitor
bind dtc_timer dtc_timer_monitor i_mon (.sys_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .event_pin_zero_out, .event_pin_zero_oe_n, .overflow_flag_zero);

// ---- testbench/tb.sv ----
/*
 * self-checking bench for dtc_timer over its register port.
 * assumes the pin model on event pin zero and a 100 MHz sys_clk.
 */
`timescale 1ns/1ps
`include "dtc_consts.vh"
module tb;
    reg        sys_clk = 1'b0;
    reg        reset_n = 1'b0;
    reg  [7:0] reg_addr = 8'h00;
    reg  [7:0] reg_wdata = 8'h00;
    reg        reg_wr = 1'b0;
    reg        reg_rd = 1'b0;
    reg        gate_pin_zero = 1'b0;
    reg        gate_pin_one = 1'b0;
    reg        start = 1'b0;
    reg  [7:0] edges = 8'h05;
    reg  [7:0] a, b, c, d, k;
    reg        prev0 = 1'b1;
    reg        prev1 = 1'b1;
    wire [7:0] reg_rdata;
    wire       src0, out0, oe0_n, out1, oe1_n, ovf0, ovf1;
    wire       pin0 = oe0_n ? src0 : out0;
    wire       pin1 = oe1_n ? 1'b1 : out1;
    integer    fails = 0;
    integer    samples_checked = 0;
    integer    cycles = 0;
    integer    toggles = 0;
    integer    toggles1 = 0;
    dtc_timer i_dut (.sys_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .event_pin_zero_in(pin0), .event_pin_zero_out(out0), .event_pin_zero_oe_n(oe0_n),
        .event_pin_one_in(pin1), .event_pin_one_out(out1), .event_pin_one_oe_n(oe1_n),
        .gate_pin_zero, .gate_pin_one, .overflow_flag_zero(ovf0),
        .overflow_flag_one(ovf1));
    dtc_pin_model i_pin (.sys_clk, .start, .edges, .pin(src0));
    always #5 sys_clk = ~sys_clk;
    task print_verdict;
        begin
            $display("checks %0d mismatches %0d", samples_checked, fails);
            if (fails == 0 && samples_checked > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    // hang guard, whole run needs about six hundred cycles
    always @(posedge sys_clk) begin
        cycles = cycles + 1;
        if (!oe0_n && out0 !== prev0)
            toggles = toggles + 1;
        prev0 = out0;
        if (!oe1_n && out1 !== prev1)
            toggles1 = toggles1 + 1;
        prev1 = out1;
        if (cycles == 3000) begin
            fails = fails + 1;
            print_verdict;
        end
    end
    task chk(input [7:0] seen, input [7:0] exp, input string name);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("[ERR] %s expected %h seen %h", name, exp, seen);
            end
        end
    endtask
    task wr(input [7:0] ad, input [7:0] dt);
        begin
            @(posedge sys_clk);
            reg_wr <= 1'b1;
            reg_addr <= ad;
            reg_wdata <= dt;
            @(posedge sys_clk);
            reg_wr <= 1'b0;
        end
    endtask
    // read data stands only in the cycle after the strobe
    task rd(input [7:0] ad, output [7:0] v);
        begin
            @(posedge sys_clk);
            reg_rd <= 1'b1;
            reg_addr <= ad;
            @(posedge sys_clk);
            reg_rd <= 1'b0;
            @(negedge sys_clk);
            v = reg_rdata;
        end
    endtask
    task rchk(input [7:0] ad, input [7:0] exp);
        reg [7:0] v;
        begin
            rd(ad, v);
            chk(v, exp, $sformatf("reg %h", ad));
        end
    endtask
    initial begin
        repeat (4) @(posedge sys_clk);
        reset_n <= 1'b1;
        for (k = 8'h88; k <= 8'h8E; k = k + 1) rchk(k, 8'h00);
        rchk(8'h90, 8'h00);
        wr(`DTC_ADDR_MODE, 8'hA5);
        rchk(`DTC_ADDR_MODE, 8'hA5);
        // both timers in 16-bit timing, reads 30 clocks apart
        wr(`DTC_ADDR_MODE, 8'h11);
        wr(`DTC_ADDR_CTRL, 8'h50);
        rd(`DTC_ADDR_TL0, a);
        rd(`DTC_ADDR_TL1, c);
        repeat (26) @(posedge sys_clk);
        rd(`DTC_ADDR_TL0, b);
        rd(`DTC_ADDR_TL1, d);
        chk(b - a, 8'h05, "tl0 rate");
        chk(d - c, 8'h05, "tl1 rate");
        wr(`DTC_ADDR_CTRL, 8'h00);
        rd(`DTC_ADDR_TL0, a);
        repeat (28) @(posedge sys_clk);
        rchk(`DTC_ADDR_TL0, a);
        // 13-bit mode: low five bits carry into the high byte
        wr(`DTC_ADDR_TL0, 8'hFF);
        wr(`DTC_ADDR_TH0, 8'h00);
        wr(`DTC_ADDR_MODE, 8'h00);
        wr(`DTC_ADDR_CTRL, 8'h10);
        repeat (8) @(posedge sys_clk);
        rchk(`DTC_ADDR_TH0, 8'h01);
        rd(`DTC_ADDR_TL0, a);
        chk(a & 8'hE0, 8'hE0, "tl0 upper");
        // auto reload with toggle output on pin zero
        wr(`DTC_ADDR_TOGGLE, 8'h01);
        wr(`DTC_ADDR_TH0, 8'hFC);
        wr(`DTC_ADDR_TL0, 8'hFE);
        wr(`DTC_ADDR_MODE, 8'h02);
        repeat (60) @(posedge sys_clk);
        rd(`DTC_ADDR_TL0, a);
        chk({7'h0, a >= 8'hFC}, 8'h01, "reload range");
        rchk(`DTC_ADDR_TH0, 8'hFC);
        chk({7'h0, ovf0}, 8'h01, "flag0");
        chk({7'h0, oe0_n}, 8'h00, "oe0");
        chk({7'h0, toggles >= 2}, 8'h01, "toggles");
        wr(`DTC_ADDR_TOGGLE, 8'h00);
        wr(`DTC_ADDR_CTRL, 8'h20);
        wr(`DTC_ADDR_CTRL, 8'h00);
        rchk(`DTC_ADDR_CTRL, 8'h00);
        chk({6'h0, oe0_n, out0}, 8'h03, "pin idle");
        // five falling edges from the pin model
        wr(`DTC_ADDR_TL0, 8'h00);
        wr(`DTC_ADDR_MODE, 8'h05);
        wr(`DTC_ADDR_CTRL, 8'h10);
        start <= 1'b1;
        @(posedge sys_clk);
        start <= 1'b0;
        repeat (150) @(posedge sys_clk);
        rchk(`DTC_ADDR_TL0, 8'h05);
        // gated timing, pin low holds then high counts
        wr(`DTC_ADDR_TL0, 8'h00);
        wr(`DTC_ADDR_MODE, 8'h09);
        repeat (30) @(posedge sys_clk);
        rchk(`DTC_ADDR_TL0, 8'h00);
        @(posedge sys_clk);
        gate_pin_zero <= 1'b1;
        repeat (30) @(posedge sys_clk);
        rd(`DTC_ADDR_TL0, a);
        chk({7'h0, a >= 8'h05 && a <= 8'h06}, 8'h01, "gated run");
        // split timer 0, timer 1 stopped, high byte under run one
        wr(`DTC_ADDR_CTRL, 8'h00);
        wr(`DTC_ADDR_TL0, 8'h00);
        wr(`DTC_ADDR_TH0, 8'h00);
        wr(`DTC_ADDR_TL1, 8'h00);
        wr(`DTC_ADDR_MODE, 8'h33);
        wr(`DTC_ADDR_CTRL, 8'h40);
        repeat (30) @(posedge sys_clk);
        rchk(`DTC_ADDR_TL0, 8'h00);
        rchk(`DTC_ADDR_TL1, 8'h00);
        rd(`DTC_ADDR_TH0, a);
        chk({7'h0, a >= 8'h05 && a <= 8'h06}, 8'h01, "th0 split");
        wr(`DTC_ADDR_TH0, 8'hFF);
        repeat (8) @(posedge sys_clk);
        rchk(`DTC_ADDR_CTRL, 8'hC0);
        chk({7'h0, ovf1}, 8'h01, "flag1 split");
        // timer 1 reload, held by gate pin one, toggling pin one
        wr(`DTC_ADDR_CTRL, 8'h00);
        wr(`DTC_ADDR_TOGGLE, 8'h02);
        wr(`DTC_ADDR_TH1, 8'hFE);
        wr(`DTC_ADDR_TL1, 8'hFE);
        wr(`DTC_ADDR_MODE, 8'hA0);
        wr(`DTC_ADDR_CTRL, 8'h40);
        repeat (30) @(posedge sys_clk);
        rchk(`DTC_ADDR_TL1, 8'hFE);
        chk({7'h0, ovf1}, 8'h00, "flag1 held");
        @(posedge sys_clk);
        gate_pin_one <= 1'b1;
        repeat (30) @(posedge sys_clk);
        rd(`DTC_ADDR_TL1, a);
        chk({7'h0, a >= 8'hFE}, 8'h01, "reload1 range");
        rchk(`DTC_ADDR_TH1, 8'hFE);
        chk({6'h0, ovf1, oe1_n}, 8'h02, "flag1 oe1");
        chk({7'h0, toggles1 >= 2}, 8'h01, "toggles1");
        print_verdict;
    end
endmodule // tb
